// *** bboc_pkg.sv ***
`default_nettype none

package bboc_pkg;

   localparam int unsigned PC_W = 15;
   localparam int unsigned DATA_W = 8;
   localparam int unsigned RADDR_W = 7;
   localparam int unsigned BIT_W = 3;
   localparam int unsigned REL_W = 9;
   localparam int unsigned CALL_W = 11;
   localparam int unsigned PAGE_W = 7;
   localparam int unsigned PAGE_LO = 3;
   localparam int unsigned PAGE_HI = 6;
   localparam logic [PC_W-1:0] PC_ONE = 15'h0001;
   localparam logic [PC_W-1:0] PC_RST = 15'h0000;
   localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
   localparam logic DEST_ACC = 1'b0;
   localparam logic DEST_FILE = 1'b1;

   typedef enum logic [2:0] {
      OP_NONE = 3'b000,
      OP_BIT_CLEAR = 3'b001,
      OP_BIT_SET = 3'b010,
      OP_LIT_BRANCH = 3'b011,
      OP_ACC_BRANCH = 3'b100,
      OP_SKIP_CLEAR = 3'b101,
      OP_SKIP_SET = 3'b110,
      OP_CALL = 3'b111
   } bboc_op_t;

   typedef enum logic {
      ST_EXEC = 1'b0,
      ST_DISCARD = 1'b1
   } bboc_state_t;

   typedef struct packed {
      bboc_op_t op;
      logic [PC_W-1:0] addr;
      logic [RADDR_W-1:0] reg_addr;
      logic [BIT_W-1:0] bit_idx;
      logic dest_sel;
      logic [CALL_W-1:0] literal;
   } bboc_issue_t;

   typedef struct packed {
      logic file_we;
      logic acc_we;
      logic [RADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
   } bboc_wb_t;

   typedef struct packed {
      logic load;
      logic discard;
      logic [PC_W-1:0] target;
   } bboc_pc_t;

   typedef struct packed {
      logic push;
      logic [PC_W-1:0] ret_addr;
   } bboc_stack_t;

endpackage : bboc_pkg

`default_nettype wire

// *** bboc_exec_unit.sv ***
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Bit clear writes zero to bit 0..7 of register 0..127; flags untouched.
// - Bit set writes one to the chosen bit; other bits and flags unchanged.
// - Literal branch sign-extends 9-bit offset; target is address plus one plus offset.
// - Literal branch takes two cycles, discarding the fetched next instruction; no flags.
// - Accumulator branch adds unsigned accumulator to address plus one; two cycles.
// - Skip-if-clear runs next instruction if bit is one, else discards it.
// - Skip-if-set runs next instruction if bit is zero, else discards it.
// - Call pushes address plus one and, in the same cycle, loads literal and page latch bits 6:3.
// - Call takes two cycles, leaves flags alone, literal spans 0 to 2047.
// - Destination select is ignored: bit ops always write the data register, never the accumulator.
module bboc_exec_unit
   import bboc_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Instruction issue from fetch
   input wire logic issue_valid,
   input wire bboc_issue_t issue,
   output logic issue_ready,
   // Operands, same cycle as issue
   input wire logic [DATA_W-1:0] operand_data,
   input wire logic [DATA_W-1:0] acc_data,
   input wire logic [PAGE_W-1:0] program_page_latch,
   // Register file and accumulator write
   output bboc_wb_t wb,
   // Program counter control
   output bboc_pc_t pc_ctl,
   // Return stack push
   output bboc_stack_t return_stack_top
);

   function automatic logic [DATA_W-1:0] bit_mask(input logic [BIT_W-1:0] idx);
      bit_mask = DATA_W'(1) << idx;
   endfunction : bit_mask

   // Shared by every opcode strobe below
   function automatic logic op_is(input bboc_op_t have, input bboc_op_t want);
      op_is = (have == want);
   endfunction : op_is

   // Field layout must tile the program counter exactly
   if (CALL_W + PAGE_HI - PAGE_LO + 1 != PC_W) begin : g_chk_call
      $error("Call target fields do not fill the program counter");
   end

   if (REL_W >= PC_W || DATA_W >= PC_W) begin : g_chk_rel
      $error("Relative offsets must be narrower than the program counter");
   end

   if ((1 << BIT_W) != DATA_W) begin : g_chk_bit
      $error("Bit index does not span the data word");
   end

   if (PAGE_HI >= PAGE_W || PAGE_LO > PAGE_HI) begin : g_chk_page
      $error("Page field lies outside the page latch");
   end

   if (DEST_ACC == DEST_FILE) begin : g_chk_dest
      $error("Destination codes must differ");
   end

   if (REL_W > CALL_W) begin : g_chk_lit
      $error("Branch offset does not fit the literal field");
   end

   bboc_state_t state_q;
   bboc_state_t state_d;
   logic ready_q;
   bboc_wb_t wb_q;
   bboc_wb_t wb_d;
   bboc_pc_t pc_q;
   bboc_pc_t pc_d;
   bboc_stack_t stk_q;
   bboc_stack_t stk_d;

   wire logic accept;
   wire logic is_clear;
   wire logic is_set;
   wire logic is_lit_br;
   wire logic is_acc_br;
   wire logic is_skip_c;
   wire logic is_skip_s;
   wire logic is_call;
   wire logic tested_bit;
   wire logic skip_taken;
   wire logic branch;
   wire logic two_cycle;
   wire logic bit_write;
   wire logic [DATA_W-1:0] mask;
   wire logic [DATA_W-1:0] bit_result;
   wire logic [PC_W-1:0] pc_next_seq;
   wire logic [PC_W-1:0] rel_ext;
   wire logic [PC_W-1:0] lit_target;
   wire logic [PC_W-1:0] acc_target;
   wire logic [PC_W-1:0] call_target;
   wire logic [PC_W-1:0] target;
   wire logic wb_to_file;
   wire logic ready_d;
   wire logic skip_clear_hit;
   wire logic skip_set_hit;
   wire logic [PC_W-1:0] rel_target;
   wire logic [PC_W-CALL_W-1:0] page_bits;

   // Accepted only outside the discard slot
   assign accept = issue_valid & ready_q;
   assign is_clear = accept & op_is(issue.op, OP_BIT_CLEAR);
   assign is_set = accept & op_is(issue.op, OP_BIT_SET);
   assign is_lit_br = accept & op_is(issue.op, OP_LIT_BRANCH);
   assign is_acc_br = accept & op_is(issue.op, OP_ACC_BRANCH);
   assign is_skip_c = accept & op_is(issue.op, OP_SKIP_CLEAR);
   assign is_skip_s = accept & op_is(issue.op, OP_SKIP_SET);
   assign is_call = accept & op_is(issue.op, OP_CALL);

   assign mask = bit_mask(issue.bit_idx);
   assign tested_bit = |(operand_data & mask);
   assign skip_clear_hit = is_skip_c & ~tested_bit;
   assign skip_set_hit = is_skip_s & tested_bit;
   assign skip_taken = skip_clear_hit | skip_set_hit;
   assign branch = is_lit_br | is_acc_br | is_call;
   assign two_cycle = branch | skip_taken;

   assign bit_write = is_clear | is_set;
   // One lane per bit keeps the untouched bits wired straight through
   for (genvar b = 0; b < DATA_W; b++) begin : g_lane
      assign bit_result[b] = mask[b] ? is_set : operand_data[b];
   end
   // Bit ops have no destination operand, so they always go back to the file
   assign wb_to_file = bit_write ? DEST_FILE : issue.dest_sel;

   // Fetch has already advanced, so every relative target starts from here
   assign pc_next_seq = issue.addr + PC_ONE;
   assign rel_ext = {{(PC_W-REL_W){issue.literal[REL_W-1]}}, issue.literal[REL_W-1:0]};
   assign lit_target = pc_next_seq + rel_ext;
   assign acc_target = pc_next_seq + {{(PC_W-DATA_W){1'b0}}, acc_data};
   assign page_bits = program_page_latch[PAGE_HI:PAGE_LO];
   assign call_target = {page_bits, issue.literal};
   assign rel_target = is_acc_br ? acc_target : lit_target;
   assign target = is_call ? call_target : rel_target;

   // The discard slot lasts one edge; nothing may start inside it
   always_comb begin
      state_d = state_q;
      case (state_q)
         ST_EXEC: begin
            if (two_cycle) begin
               state_d = ST_DISCARD;
            end
         end
         ST_DISCARD: begin
            state_d = ST_EXEC;
         end
      endcase
   end
   assign ready_d = (state_d == ST_EXEC);

   always_comb begin
      wb_d.file_we = bit_write & (wb_to_file == DEST_FILE);
      wb_d.acc_we = bit_write & (wb_to_file == DEST_ACC);
      wb_d.addr = issue.reg_addr;
      wb_d.data = bit_result;
   end

   always_comb begin
      pc_d.load = branch;
      pc_d.discard = two_cycle;
      pc_d.target = target;
   end

   always_comb begin
      stk_d.push = is_call;
      stk_d.ret_addr = pc_next_seq;
   end

   // Flags are never written by this group, so no flag port exists
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state_q <= ST_EXEC;
         ready_q <= 1'b1;
      end else begin
         state_q <= state_d;
         ready_q <= ready_d;
      end
   end

   // Strobes last one cycle because the next value is rebuilt every edge
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         wb_q <= '0;
      end else begin
         wb_q <= wb_d;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         pc_q <= '0;
      end else begin
         pc_q <= pc_d;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         stk_q <= '0;
      end else begin
         stk_q <= stk_d;
      end
   end

   assign issue_ready = ready_q;
   assign wb = wb_q;
   assign pc_ctl = pc_q;
   assign return_stack_top = stk_q;

endmodule : bboc_exec_unit

`default_nettype wire

// *** bboc_exec_unit_sva.sv ***
`timescale 1ns/1ps
`default_nettype none
module bboc_exec_unit_sva
   import bboc_pkg::*;
(
   // Watched ports
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic issue_valid,
   input wire bboc_issue_t issue,
   input wire logic issue_ready,
   input wire logic [DATA_W-1:0] operand_data,
   input wire logic [DATA_W-1:0] acc_data,
   input wire logic [PAGE_W-1:0] program_page_latch,
   input wire bboc_wb_t wb,
   input wire bboc_pc_t pc_ctl,
   input wire bboc_stack_t return_stack_top
);
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   wire logic k = issue_valid && issue_ready;
   wire logic [2:0] op = issue.op;
   wire logic tw = k && (op == OP_LIT_BRANCH || op == OP_ACC_BRANCH || op == OP_CALL);
   wire logic bo = k && (op == OP_BIT_SET || op == OP_BIT_CLEAR);
   wire logic bt = operand_data[issue.bit_idx];
   wire logic [14:0] nx = issue.addr + 15'h0001;
   wire logic [14:0] lt = nx + 15'($signed(issue.literal[8:0]));
   wire logic [14:0] at = nx + {7'h00, acc_data};
   wire logic [14:0] ct = {program_page_latch[6:3], issue.literal};
   wire logic [7:0] sv = operand_data | (8'h01 << issue.bit_idx);
   a_clr_bit: assert property (k && op == OP_BIT_CLEAR |=> !wb.data[$past(issue.bit_idx)])
      else $error("clear");
   a_set_bit: assert property (k && op == OP_BIT_SET |=> wb.data[$past(issue.bit_idx)])
      else $error("set");
   a_lit_tgt: assert property (k && op == OP_LIT_BRANCH |=> pc_ctl.target == $past(lt))
      else $error("target");
   a_set_keep: assert property (k && op == OP_BIT_SET |=> wb.data == $past(sv))
      else $error("set others");
   a_acc_tgt: assert property (k && op == OP_ACC_BRANCH |=> pc_ctl.target == $past(at))
      else $error("acc target");
   a_call_tgt: assert property (k && op == OP_CALL |=> pc_ctl.target == $past(ct))
      else $error("call target");
   a_two_cyc: assert property (tw
      |=> pc_ctl.discard && !issue_ready ##1 issue_ready) else $error("slot");
   a_load_once: assert property (pc_ctl.load |=> !pc_ctl.load && !pc_ctl.discard)
      else $error("load twice");
   a_skc_disc: assert property (k && op == OP_SKIP_CLEAR |=> pc_ctl.discard != $past(bt))
      else $error("skip");
   a_sks_disc: assert property (k && op == OP_SKIP_SET |=> pc_ctl.discard == $past(bt))
      else $error("skip");
   a_call_push: assert property (k && op == OP_CALL |=> return_stack_top.push
      && return_stack_top.ret_addr == $past(nx)) else $error("push");
   a_bit_dest: assert property (bo |=> wb.file_we && !wb.acc_we) else $error("dest");
   a_one_cyc: assert property (bo |=> issue_ready && !pc_ctl.load) else $error("one");
   c_call: cover property (k && op == OP_CALL);
   c_skip: cover property (pc_ctl.discard && !pc_ctl.load);
   c_bit: cover property (bo);
endmodule : bboc_exec_unit_sva
bind bboc_exec_unit bboc_exec_unit_sva bboc_exec_unit_sva_inst (.clk(clk), .sys_rst(sys_rst),
   .issue_valid(issue_valid), .issue(issue), .issue_ready(issue_ready),
   .operand_data(operand_data), .acc_data(acc_data), .program_page_latch(program_page_latch),
   .wb(wb), .pc_ctl(pc_ctl), .return_stack_top(return_stack_top));
`default_nettype wire

// *** bboc_regfile_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module bboc_regfile_model
   import bboc_pkg::*;
(
   // Register file side
   input wire logic clk,
   input wire logic [RADDR_W-1:0] raddr,
   input wire bboc_wb_t wb,
   output logic [DATA_W-1:0] rdata
);
   logic [DATA_W-1:0] mem [128] = '{default: 8'h00};
   // No bypass: a write is seen only from the next edge on
   assign rdata = mem[raddr];
   always @(posedge clk) if (wb.file_we) mem[wb.addr] <= wb.data;
endmodule : bboc_regfile_model
`default_nettype wire

// *** test_bit_op_branch_call_exec.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin errors++; \
   $display("ERROR %0t bad", $time); end end
module test_bit_op_branch_call_exec
   import bboc_pkg::*;
;
   logic clk = 1'b0, sys_rst = 1'b1, issue_valid = 1'b0, issue_ready;
   logic [7:0] operand_data, acc_data = 8'h00;
   logic [6:0] program_page_latch = 7'h00;
   bboc_issue_t issue = '0;
   bboc_wb_t wb;
   bboc_pc_t pc_ctl;
   bboc_stack_t return_stack_top;
   int errors = 0, num_checks = 0, cyc = 0;
   bboc_exec_unit bboc_exec_unit_inst (.clk(clk), .sys_rst(sys_rst), .issue_valid(issue_valid),
      .issue(issue), .issue_ready(issue_ready), .operand_data(operand_data), .acc_data(acc_data),
      .program_page_latch(program_page_latch), .wb(wb), .pc_ctl(pc_ctl),
      .return_stack_top(return_stack_top));
   bboc_regfile_model bboc_regfile_model_inst (.clk(clk), .raddr(issue.reg_addr), .wb(wb),
      .rdata(operand_data));
   always #12.5 clk = ~clk;
   always @(posedge clk) if (++cyc == 900) begin
      errors++;
      summarize();
   end
   task automatic summarize;
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : summarize
   // One idle cycle after each issue keeps two-cycle ops legal
   task automatic go(bboc_op_t o, logic [14:0] a, logic [2:0] b, logic [10:0] l);
      @(negedge clk);
      issue = '{o, a, 7'h7F, b, 1'b1, l};
      issue_valid = 1'b1;
      @(negedge clk);
      issue_valid = 1'b0;
   endtask : go
   // Chained on one register, then both tests on the all-s result
   task automatic t_bits(logic s);
      for (int i = 0; i < 8; i++) begin
         go(bboc_op_t'(s ? OP_BIT_SET : OP_BIT_CLEAR), 15'h0000, 3'(i), 11'h000);
         `CHK(wb.data, s ? 8'hFF >> (7 - i) : 8'hFE << i)
         `CHK({wb.file_we, wb.acc_we, wb.addr, issue_ready}, 10'h2FF)
      end
      go(OP_SKIP_CLEAR, 15'h0000, 3'h5, 11'h000);
      `CHK({pc_ctl.discard, issue_ready}, {!s, s})
      go(OP_SKIP_SET, 15'h0000, 3'h0, 11'h000);
      `CHK({pc_ctl.load, pc_ctl.discard, issue_ready}, {1'b0, s, !s})
   endtask : t_bits
   task automatic t_branch;
      acc_data = 8'hFF;
      go(OP_LIT_BRANCH, 15'h0010, 3'h0, 11'h1FE);
      `CHK({pc_ctl, issue_ready}, {2'b11, 15'h000F, 1'b0})
      go(OP_LIT_BRANCH, 15'h0100, 3'h0, 11'h700);
      `CHK(pc_ctl.target, 15'h0001)
      go(OP_ACC_BRANCH, 15'h0010, 3'h0, 11'h000);
      `CHK({pc_ctl, issue_ready}, {2'b11, 15'h0110, 1'b0})
      `CHK({wb.file_we, return_stack_top.push}, 2'b00)
   endtask : t_branch
   task automatic t_call;
      program_page_latch = 7'h78;
      go(OP_CALL, 15'h0020, 3'h0, 11'h7FF);
      `CHK(return_stack_top, {1'b1, 15'h0021})
      `CHK({pc_ctl, issue_ready}, {2'b11, 15'h7FFF, 1'b0})
      @(negedge clk);
      `CHK({pc_ctl.load, return_stack_top.push, issue_ready}, 3'b001)
      program_page_latch = 7'h07;
      go(OP_CALL, 15'h1234, 3'h0, 11'h5A5);
      `CHK(pc_ctl.target, 15'h05A5)
   endtask : t_call
   // Reset lands in a call's discard slot; the slot must not survive it
   task automatic t_reset;
      go(OP_CALL, 15'h0040, 3'h0, 11'h123);
      sys_rst = 1'b1;
      @(negedge clk);
      `CHK({wb, pc_ctl, return_stack_top}, '0)
      `CHK(issue_ready, 1'b1)
      sys_rst = 1'b0;
      go(OP_BIT_SET, 15'h0000, 3'h2, 11'h000);
      `CHK(wb.data, 8'h04)
   endtask : t_reset
   initial begin
      repeat (10) @(negedge clk);
      sys_rst = 1'b0;
      t_bits(1'b1);
      t_bits(1'b0);
      t_branch;
      t_call;
      t_reset;
      summarize();
   end
endmodule : test_bit_op_branch_call_exec
`default_nettype wire
